//--- logic/t2cf_pkg.sv
// Constants for the second timer control and flag logic
// Function
// - Hardware sets the overflow flag when the 16-bit count overflows and only software clears it.
// - The overflow flag is not set while any baud-clock select or the clock-out enable is 1.
// - The external flag is set when a trigger falling edge causes capture or reload, only with the trigger enabled.
// - The external flag raises the timer interrupt when enabled and only a software write clears it.
// - A set first-port receive or transmit select makes this timer's overflow that direction's baud clock.
// - Capture or reload from a trigger falling edge happens only while the trigger enable is set.
// - Select at 1 counts falling edges of the count input, at 0 counts internal clock ticks.
// - In capture mode with trigger enabled a trigger falling edge copies the count bytes to the capture bytes.
// - In reload mode with trigger enabled and no baud-clock select a reload happens on overflow or on a trigger falling edge.
// - In reload mode with no baud-clock select an overflow loads the count from the software reload value; with one set it wraps to 0.
package t2cf_pkg;
    localparam logic [11:0] ADDR_CONTROL = 12'h418;
    localparam logic [11:0] ADDR_MODE = 12'h41C;
    localparam logic [11:0] ADDR_COUNT = 12'h420;
    localparam logic [11:0] ADDR_CAPTURE = 12'h424;
    localparam logic [11:0] ADDR_IRQ_STATUS = 12'h428;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'h42C;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam int BIT_OVF = 7;
    localparam int BIT_EXT = 6;
    localparam int BIT_RX0 = 5;
    localparam int BIT_TX0 = 4;
    localparam int BIT_EXEN = 3;
    localparam int BIT_RUN = 2;
    localparam int BIT_CT = 1;
    localparam int BIT_CPRL = 0;
    localparam int MBIT_RX1 = 2;
    localparam int MBIT_TX1 = 1;
    localparam int MBIT_OE = 0;
    localparam int IBIT_OVF = 0;
    localparam int IBIT_EXT = 1;
    localparam int IBIT_RAW_OVF = 2;
endpackage

//--- logic/t2cf_timer.sv
// Second timer: count, capture, reload, flags, baud select and APB slave
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module t2cf_timer (
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic count_input,
    input wire logic external_trigger_input,
    input wire logic timer1_overflow,
    output logic uart0_rx_baud_tick,
    output logic uart0_tx_baud_tick,
    output logic uart1_rx_baud_tick,
    output logic uart1_tx_baud_tick,
    output logic timer_irq
);
    logic [7:0] control_reg;
    logic [7:0] control_next;
    logic [2:0] mode_reg;
    logic [15:0] count_reg;
    logic [15:0] count_next;
    logic [15:0] capture_reg;
    logic [15:0] capture_next;
    logic [2:0] irq_status_reg;
    logic [2:0] irq_status_next;
    logic [2:0] irq_mask_reg;
    logic count_in_q;
    logic trig_in_q;
    logic [31:0] prdata_next;

    wire access = psel && penable;
    wire wr = access && pwrite;
    wire rd = access && !pwrite;
    wire sel_ctl = paddr == t2cf_pkg::ADDR_CONTROL;
    wire sel_mode = paddr == t2cf_pkg::ADDR_MODE;
    wire sel_cnt = paddr == t2cf_pkg::ADDR_COUNT;
    wire sel_cap = paddr == t2cf_pkg::ADDR_CAPTURE;
    wire sel_ist = paddr == t2cf_pkg::ADDR_IRQ_STATUS;
    wire sel_imk = paddr == t2cf_pkg::ADDR_IRQ_MASK;
    wire mapped = sel_ctl | sel_mode | sel_cnt | sel_cap | sel_ist | sel_imk;

    wire run_control = control_reg[t2cf_pkg::BIT_RUN];
    wire counter_timer_select = control_reg[t2cf_pkg::BIT_CT];
    wire capture_reload_select = control_reg[t2cf_pkg::BIT_CPRL];
    wire external_trigger_enable = control_reg[t2cf_pkg::BIT_EXEN];
    wire uart0_rx_baud_select = control_reg[t2cf_pkg::BIT_RX0];
    wire uart0_tx_baud_select = control_reg[t2cf_pkg::BIT_TX0];
    wire uart1_rx_baud_select = mode_reg[t2cf_pkg::MBIT_RX1];
    wire uart1_tx_baud_select = mode_reg[t2cf_pkg::MBIT_TX1];
    wire clock_out_enable = mode_reg[t2cf_pkg::MBIT_OE];

    // Falling edges of the synchronous pins
    wire count_fall = count_in_q && !count_input;
    wire trig_fall = trig_in_q && !external_trigger_input;
    wire tick = counter_timer_select ? count_fall : 1'b1;
    wire advance = run_control && tick;
    wire overflow = advance && (count_reg == 16'hFFFF);
    wire trig_event = trig_fall && external_trigger_enable;
    wire cap_event = trig_event && capture_reload_select;
    wire baud_any = uart0_rx_baud_select | uart0_tx_baud_select | uart1_rx_baud_select
        | uart1_tx_baud_select;
    wire ovf_block = baud_any | clock_out_enable;
    wire ovf_set = overflow && !ovf_block;
    wire ext_set = trig_event;
    wire reload_event = !capture_reload_select && !baud_any
        && (overflow || trig_event);

    // Software clears flags by writing 0; hardware set wins
    wire ctl_wr = wr && sel_ctl;
    wire ovf_keep = ctl_wr ? pwdata[t2cf_pkg::BIT_OVF] & control_reg[t2cf_pkg::BIT_OVF]
        : control_reg[t2cf_pkg::BIT_OVF];
    wire ext_keep = ctl_wr ? pwdata[t2cf_pkg::BIT_EXT] & control_reg[t2cf_pkg::BIT_EXT]
        : control_reg[t2cf_pkg::BIT_EXT];
    wire [5:0] ctl_low = ctl_wr ? pwdata[5:0] : control_reg[5:0];

    always_comb begin
        control_next = {ovf_keep | ovf_set, ext_keep | ext_set, ctl_low};
        if (wr && sel_cnt) begin
            count_next = pwdata[15:0];
        end else if (reload_event) begin
            count_next = capture_reg;
        end else if (advance) begin
            count_next = count_reg + 16'h0001;
        end else begin
            count_next = count_reg;
        end
        if (cap_event) begin
            capture_next = count_reg;
        end else if (wr && sel_cap) begin
            capture_next = pwdata[15:0];
        end else begin
            capture_next = capture_reg;
        end
        irq_status_next = irq_status_reg;
        // Clear only what the read returned; an event in the setup cycle survives
        if (rd && sel_ist) begin
            irq_status_next = irq_status_reg & ~prdata[2:0];
        end
        irq_status_next[t2cf_pkg::IBIT_OVF] = irq_status_next[t2cf_pkg::IBIT_OVF] | ovf_set;
        irq_status_next[t2cf_pkg::IBIT_EXT] = irq_status_next[t2cf_pkg::IBIT_EXT] | ext_set;
        irq_status_next[t2cf_pkg::IBIT_RAW_OVF] =
            irq_status_next[t2cf_pkg::IBIT_RAW_OVF] | overflow;
        prdata_next = 32'h0;
        if (sel_ctl) begin
            prdata_next = {24'h0, control_reg};
        end else if (sel_mode) begin
            prdata_next = {29'h0, mode_reg};
        end else if (sel_cnt) begin
            prdata_next = {16'h0, count_reg};
        end else if (sel_cap) begin
            prdata_next = {16'h0, capture_reg};
        end else if (sel_ist) begin
            prdata_next = {29'h0, irq_status_reg};
        end else if (sel_imk) begin
            prdata_next = {29'h0, irq_mask_reg};
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            control_reg <= t2cf_pkg::CONTROL_RESET;
            mode_reg <= 3'h0;
            count_reg <= 16'h0000;
            capture_reg <= 16'h0000;
            irq_status_reg <= 3'h0;
            irq_mask_reg <= 3'h0;
            count_in_q <= 1'b0;
            trig_in_q <= 1'b0;
        end else begin
            control_reg <= control_next;
            count_reg <= count_next;
            capture_reg <= capture_next;
            irq_status_reg <= irq_status_next;
            count_in_q <= count_input;
            trig_in_q <= external_trigger_input;
            if (wr && sel_mode) begin
                mode_reg <= pwdata[2:0];
            end
            if (wr && sel_imk) begin
                irq_mask_reg <= pwdata[2:0];
            end
        end
    end

    // Bus answer: ready during every access phase, error on unmapped
    always_ff @(posedge clock) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata <= prdata_next;
        end
    end

    // Baud ticks and interrupt
    always_ff @(posedge clock) begin
        if (rst) begin
            uart0_rx_baud_tick <= 1'b0;
            uart0_tx_baud_tick <= 1'b0;
            uart1_rx_baud_tick <= 1'b0;
            uart1_tx_baud_tick <= 1'b0;
            timer_irq <= 1'b0;
        end else begin
            uart0_rx_baud_tick <= uart0_rx_baud_select ? overflow : timer1_overflow;
            uart0_tx_baud_tick <= uart0_tx_baud_select ? overflow : timer1_overflow;
            uart1_rx_baud_tick <= uart1_rx_baud_select ? overflow : timer1_overflow;
            uart1_tx_baud_tick <= uart1_tx_baud_select ? overflow : timer1_overflow;
            timer_irq <= |(irq_status_next & irq_mask_reg);
        end
    end
endmodule
`default_nettype wire

//--- verif/t2cf_pins.sv
// Count and trigger pins of the second timer, idle high
`timescale 1ns/1ps
`default_nettype none
module t2cf_pins (
    input wire logic clock,
    input wire logic cnt_req,
    input wire logic trg_req,
    output logic count_input,
    output logic external_trigger_input
);
    initial begin
        count_input = 1'b1;
        external_trigger_input = 1'b1;
    end
    // One low cycle per request
    always @(posedge clock) begin
        count_input <= !cnt_req;
        external_trigger_input <= !trg_req;
    end
endmodule
`default_nettype wire

//--- verif/t2cf_chk.sv
// Bus and interrupt checks on the second timer ports
`timescale 1ns/1ps
`default_nettype none
module t2cf_chk (
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic timer_irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    wire setup = psel && !penable;
    wire bad = paddr < 12'h418 || paddr > 12'h42C || paddr[1:0] != 2'h0;
    property p_setup; setup |=> pready; endproperty
    a_setup: assert property (p_setup) else $error("no ready after setup");
    property p_acc; pready |-> psel && penable && $past(setup); endproperty
    a_acc: assert property (p_acc) else $error("ready outside access");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("ready too long");
    property p_err; setup && bad |=> pslverr && pready; endproperty
    a_err: assert property (p_err) else $error("unmapped not refused");
    property p_ok; setup && !bad |=> !pslverr; endproperty
    a_ok: assert property (p_ok) else $error("mapped refused");
    property p_rd0; pslverr && !pwrite |-> prdata == 32'h0; endproperty
    a_rd0: assert property (p_rd0) else $error("unmapped read not zero");
    property p_rel; $fell(rst) |-> !pready && !pslverr && !timer_irq; endproperty
    a_rel: assert property (p_rel) else $error("outputs not cleared");
    property p_irq; $fell(timer_irq) |-> $past(pready); endproperty
    a_irq: assert property (p_irq) else $error("irq fell without access");
endmodule
bind t2cf_timer t2cf_chk chk (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_irq(timer_irq));
`default_nettype wire

//--- verif/t2cf_timer_bench.sv
// Register-level bench for the second timer
`timescale 1ns/1ps
`default_nettype none
module t2cf_timer_bench;
    logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, t1_ovf = 0;
    logic cnt_req = 0, trg_req = 0, pready, pslverr, cnt_in, trg_in, rx0, tx0, irq;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    int errors = 0, checks_done = 0, rx_n = 0, tx_n = 0;
    always #50 clock = ~clock;
    always @(posedge clock) begin
        rx_n += rx0;
        tx_n += tx0;
    end
    t2cf_pins pins (.clock(clock), .cnt_req(cnt_req), .trg_req(trg_req),
        .count_input(cnt_in), .external_trigger_input(trg_in));
    t2cf_timer DUT (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .count_input(cnt_in), .external_trigger_input(trg_in), .timer1_overflow(t1_ovf),
        .uart0_rx_baud_tick(rx0), .uart0_tx_baud_tick(tx0), .uart1_rx_baud_tick(),
        .uart1_tx_baud_tick(), .timer_irq(irq));
    task summarize;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            errors++;
            summarize;
        end
        @(posedge clock);
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    // One falling edge on the count pin or the trigger pin
    task pin(input logic c);
        if (c) cnt_req <= 1'b1;
        else trg_req <= 1'b1;
        @(posedge clock);
        cnt_req <= 1'b0;
        trg_req <= 1'b0;
        repeat (6) @(posedge clock);
    endtask
    initial begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rd(12'h418, 32'h00);
        rd(12'h430, 32'h00);
        wr(12'h424, 32'h1234);
        wr(12'h420, 32'hFFFF);
        repeat (5) @(posedge clock);
        rd(12'h420, 32'hFFFF);
        wr(12'h418, 32'h06);
        rd(12'h420, 32'hFFFF);
        pin(1'b1);
        rd(12'h420, 32'h1234);
        pin(1'b1);
        rd(12'h420, 32'h1235);
        rd(12'h418, 32'h86);
        rd(12'h428, 32'h05);
        wr(12'h42C, 32'h02);
        wr(12'h418, 32'h0F);
        pin(1'b0);
        rd(12'h424, 32'h1235);
        rd(12'h418, 32'h4F);
        chk({31'h0, irq}, 32'h1);
        rd(12'h428, 32'h02);
        chk({31'h0, irq}, 32'h0);
        rd(12'h418, 32'h4F);
        wr(12'h418, 32'h07);
        pin(1'b0);
        rd(12'h418, 32'h07);
        rd(12'h424, 32'h1235);
        wr(12'h420, 32'hFFFF);
        wr(12'h418, 32'h26);
        pin(1'b1);
        t1_ovf <= 1'b1;
        @(posedge clock);
        t1_ovf <= 1'b0;
        repeat (3) @(posedge clock);
        rd(12'h418, 32'h26);
        chk(32'(rx_n), 32'h1);
        chk(32'(tx_n), 32'h1);
        rd(12'h420, 32'h0000);
        wr(12'h41C, 32'h01);
        wr(12'h418, 32'h06);
        wr(12'h420, 32'hFFFF);
        pin(1'b1);
        rd(12'h418, 32'h06);
        wr(12'h41C, 32'h00);
        wr(12'h420, 32'h0010);
        wr(12'h418, 32'h0E);
        pin(1'b0);
        rd(12'h420, 32'h1235);
        rd(12'h418, 32'h4E);
        summarize;
    end
endmodule
`default_nettype wire
